// ---- rtl/btnp_baseline.sv ----
`timescale 1ns/1ps
// per-channel baseline tracker with fractional accumulation
module btnp_baseline (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step_en,
  input wire logic [btnp_pkg::DW-1:0] meas,
  input wire logic [7:0] idx,
  input wire logic low_power,
  input wire logic cont_samp,
  input wire logic [1:0] speedup,
  input wire logic freeze,
  output logic signed [btnp_pkg::DW+1:0] value
);
  localparam int BW = btnp_pkg::DW + btnp_pkg::FRAC;
  logic [btnp_pkg::DW+btnp_pkg::FRAC-1:0] base_r;
  logic [btnp_pkg::DW+btnp_pkg::FRAC-1:0] step;
  logic [btnp_pkg::DW+btnp_pkg::FRAC-1:0] raw;
  logic [btnp_pkg::DW+btnp_pkg::FRAC-1:0] scaled;
  logic [btnp_pkg::DW+btnp_pkg::FRAC-1:0] target;
  logic [4:0] sh;
  logic neg;

  assign target = {meas, {btnp_pkg::FRAC{1'b0}}};
  // processed value: measurement minus integer part of baseline
  assign value = $signed({2'b00, meas}) -
    $signed({2'b00, base_r[btnp_pkg::DW+btnp_pkg::FRAC-1:btnp_pkg::FRAC]});
  assign neg = value < 0;
  assign sh = (idx[4:0] > 5'd14) ? 5'd14 : idx[4:0];

  // step = 2^idx / div, in units of 1/2^FRAC
  always_comb begin
    raw = '0;
    raw[btnp_pkg::FRAC +: 15] = 15'h0001 << sh;
    if (cont_samp) begin
      step = btnp_pkg::FIXED_STEP;
    end else if (low_power) begin
      step = BW'(raw / btnp_pkg::LP_DIV);
    end else begin
      step = BW'(raw / btnp_pkg::NP_DIV);
    end
    if (step == '0) begin
      step = 24'h000001;
    end
    case (speedup)
      2'b01: scaled = step << 2;
      2'b10: scaled = step << 3;
      2'b11: scaled = step << 4;
      default: scaled = step;
    endcase
    if (!neg) begin
      scaled = step;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      base_r <= '0;
    end else if (step_en && !freeze) begin
      if (base_r + scaled <= target && base_r < target) begin
        base_r <= base_r + scaled;
      end else if (base_r > target + scaled) begin
        base_r <= base_r - scaled;
      end else begin
        base_r <= target;
      end
    end
  end
endmodule

// ---- rtl/btnp_pkg.sv ----
// constants and types for the button post-processing block
package btnp_pkg;
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int FRAC = 8;
  // register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_EN = 8'h0c;
  localparam logic [7:0] REG_INTERRUPT_POLARITY = 8'h11;
  localparam logic [7:0] REG_LP_STEP = 8'h13;
  localparam logic [7:0] REG_NP_STEP = 8'h15;
  localparam logic [7:0] REG_PAUSE_GRP = 8'h16;
  localparam logic [7:0] REG_THRESHOLD_HYSTERESIS = 8'h18;
  localparam logic [7:0] REG_TWIST = 8'h19;
  localparam logic [7:0] REG_COMDEF = 8'h1a;
  localparam logic [7:0] REG_SPD0 = 8'h25;
  localparam logic [7:0] REG_SPD12 = 8'h28;
  localparam logic [7:0] REG_SPD3 = 8'h2b;
  // reset values
  localparam logic [7:0] THRESHOLD_HYSTERESIS_RST = 8'h20;
  localparam logic [7:0] INTERRUPT_POLARITY_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h0f;
  localparam logic [7:0] STEP_RST = 8'h03;
  // thresholds
  localparam logic signed [DW+1:0] NOMINAL = 18'sh00080;
  // baseline step divisors, with fractional scale
  localparam int NP_DIV = 72;
  localparam int LP_DIV = 9;
  localparam logic [DW+FRAC-1:0] FIXED_STEP = 24'h000040;
  // status bit positions
  localparam int ST_OUT = 0;
  localparam int ST_ERR = 1;
  localparam int ST_RDY = 2;
  // twist enable bit position
  localparam int TW_EN = 7;
  typedef enum logic [2:0] {
    BTNP_IDLE = 3'b001,
    BTNP_CHAN = 3'b010,
    BTNP_DONE = 3'b100
  } btnp_state_t;
endpackage

// ---- rtl/btnp_top.sv ----
`timescale 1ns/1ps
// button detection post-processing: thresholds, baseline, filters, irq
module btnp_top #(
  parameter int NCH = btnp_pkg::NCH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic window_done,
  input wire logic [NCH*btnp_pkg::DW-1:0] meas,
  input wire logic raw_mode,
  input wire logic error_evt,
  input wire logic continuous_sampling_select,
  input wire logic power_mode_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [NCH-1:0] button_output_pin,
  output logic irq_pin
);
  // pin-level inputs synchronised
  logic [1:0] pm_sync_r;
  logic [1:0] win_sync_r;
  logic win_last_r;
  logic tick;
  logic low_power;

  logic [7:0] status_r;
  logic [7:0] en_r;
  logic [7:0] interrupt_polarity_r;
  logic [7:0] lp_step_r;
  logic [7:0] np_step_r;
  logic [7:0] pause_grp_r;
  logic [7:0] threshold_hysteresis_r;
  logic [7:0] twist_r;
  logic [7:0] comdef_r;
  logic [7:0] spd0_r;
  logic [7:0] spd12_r;
  logic [7:0] spd3_r;

  logic [NCH-1:0] pressed_r;
  logic [NCH-1:0] pressed_nxt;
  logic [NCH-1:0] out_r;
  logic irq_r;
  logic [2:0] ch_r;
  btnp_pkg::btnp_state_t state_r;

  logic signed [btnp_pkg::DW+1:0] value [NCH];
  logic [1:0] speed [NCH];
  logic signed [btnp_pkg::DW+1:0] thr_on;
  logic signed [btnp_pkg::DW+1:0] thr_off;
  logic signed [btnp_pkg::DW+1:0] twist_lim;
  logic twisted;
  logic [NCH-1:0] cand;
  logic [NCH-1:0] filt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pm_sync_r <= 2'b00;
      win_sync_r <= 2'b00;
      win_last_r <= 1'b0;
    end else begin
      pm_sync_r <= {pm_sync_r[0], power_mode_pin};
      win_sync_r <= {win_sync_r[0], window_done};
      win_last_r <= win_sync_r[1];
    end
  end
  assign tick = win_sync_r[1] && !win_last_r;
  assign low_power = !pm_sync_r[1];

  assign speed[0] = spd0_r[1:0];
  assign speed[1] = spd12_r[1:0];
  assign speed[2] = spd12_r[5:4];
  assign speed[3] = spd3_r[1:0];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      btnp_baseline u_base (
        .sys_clk(sys_clk),
        .rst(rst),
        // tracking skipped in raw mode and for disabled channels
        .step_en(tick && !raw_mode && en_r[g]),
        .meas(meas[g*btnp_pkg::DW +: btnp_pkg::DW]),
        .idx(low_power ? lp_step_r : np_step_r),
        .low_power(low_power),
        .cont_samp(continuous_sampling_select && !low_power),
        .speedup(speed[g % 4]),
        .freeze(pause_grp_r[g] && out_r[g]),
        .value(value[g])
      );
    end
  endgenerate

  assign thr_on = btnp_pkg::NOMINAL + $signed({10'h000, threshold_hysteresis_r});
  assign thr_off = btnp_pkg::NOMINAL - $signed({10'h000, threshold_hysteresis_r});
  assign twist_lim = -$signed({11'h000, twist_r[6:0]});

  // hysteresis comparison and anti-twist
  always_comb begin
    twisted = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (en_r[i] && value[i] < twist_lim) begin
        twisted = 1'b1;
      end
    end
    if (!twist_r[btnp_pkg::TW_EN]) begin
      twisted = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      if (!en_r[i]) begin
        cand[i] = 1'b0;
      end else if (pressed_r[i]) begin
        cand[i] = value[i] > thr_off;
      end else begin
        cand[i] = (value[i] >= thr_on) && !twisted;
      end
    end
  end

  // group filters: anti-common drops the higher-numbered members of a group whose values lie within
  // hysteresis of another; anti-deform drops the weaker members; max-win keeps the strongest only
  always_comb begin
    filt = cand;
    for (int i = 0; i < NCH; i++) begin
      for (int j = 0; j < NCH; j++) begin
        if (i != j && cand[i] && cand[j]) begin
          if (comdef_r[i] && comdef_r[j] && value[j] < value[i] +
              $signed({10'h000, threshold_hysteresis_r}) && value[i] < value[j] +
              $signed({10'h000, threshold_hysteresis_r}) && j < i) begin
            filt[i] = 1'b0;
          end
          if (comdef_r[4+i] && comdef_r[4+j] && value[j] > value[i]) begin
            filt[i] = 1'b0;
          end
          if (pause_grp_r[4+i] && pause_grp_r[4+j] &&
              (value[j] > value[i] || (value[j] == value[i] && j < i))) begin
            filt[i] = 1'b0;
          end
        end
      end
    end
  end

  // channel walk once per window, in channel order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= btnp_pkg::BTNP_IDLE;
      ch_r <= 3'h0;
      pressed_nxt <= '0;
    end else begin
      case (state_r)
        btnp_pkg::BTNP_IDLE: begin
          if (tick) begin
            state_r <= btnp_pkg::BTNP_CHAN;
            ch_r <= 3'h0;
          end
        end
        btnp_pkg::BTNP_CHAN: begin
          pressed_nxt[ch_r[1:0]] <= filt[ch_r[1:0]];
          if (ch_r == 3'(NCH - 1)) begin
            state_r <= btnp_pkg::BTNP_DONE;
          end
          ch_r <= ch_r + 3'h1;
        end
        btnp_pkg::BTNP_DONE: begin
          state_r <= btnp_pkg::BTNP_IDLE;
        end
        default: state_r <= btnp_pkg::BTNP_IDLE;
      endcase
    end
  end

  // outputs update together at the window end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pressed_r <= '0;
      out_r <= '0;
    end else if (state_r == btnp_pkg::BTNP_DONE) begin
      pressed_r <= raw_mode ? '0 : pressed_nxt;
      out_r <= raw_mode ? '0 : pressed_nxt;
    end
  end
  assign button_output_pin = out_r;

  // status flags: set wins over the read clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= 8'h00;
    end else begin
      if (reg_rd && reg_addr == btnp_pkg::REG_STATUS) begin
        status_r <= 8'h00;
      end
      if (state_r == btnp_pkg::BTNP_DONE && !raw_mode &&
          |pressed_nxt && !(|pressed_r)) begin
        status_r[btnp_pkg::ST_OUT] <= 1'b1;
      end
      if (error_evt) begin
        status_r[btnp_pkg::ST_ERR] <= 1'b1;
      end
      if (state_r == btnp_pkg::BTNP_DONE && raw_mode) begin
        status_r[btnp_pkg::ST_RDY] <= 1'b1;
      end
    end
  end

  // level irq: any pressed button, pending error or raw data ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (|pressed_r) || status_r[btnp_pkg::ST_ERR] || error_evt ||
        (raw_mode && status_r[btnp_pkg::ST_RDY]);
    end
  end
  // active low unless polarity bit set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pin <= 1'b1;
    end else begin
      irq_pin <= interrupt_polarity_r[0] ? irq_r : !irq_r;
    end
  end

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_r <= btnp_pkg::EN_RST;
      interrupt_polarity_r <= btnp_pkg::INTERRUPT_POLARITY_RST;
      lp_step_r <= btnp_pkg::STEP_RST;
      np_step_r <= btnp_pkg::STEP_RST;
      pause_grp_r <= 8'h00;
      threshold_hysteresis_r <= btnp_pkg::THRESHOLD_HYSTERESIS_RST;
      twist_r <= 8'h00;
      comdef_r <= 8'h00;
      spd0_r <= 8'h00;
      spd12_r <= 8'h00;
      spd3_r <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        btnp_pkg::REG_EN: en_r <= reg_wdata;
        btnp_pkg::REG_INTERRUPT_POLARITY: interrupt_polarity_r <= reg_wdata;
        btnp_pkg::REG_LP_STEP: lp_step_r <= reg_wdata;
        btnp_pkg::REG_NP_STEP: np_step_r <= reg_wdata;
        btnp_pkg::REG_PAUSE_GRP: pause_grp_r <= reg_wdata;
        btnp_pkg::REG_THRESHOLD_HYSTERESIS: threshold_hysteresis_r <= reg_wdata;
        btnp_pkg::REG_TWIST: twist_r <= reg_wdata;
        btnp_pkg::REG_COMDEF: comdef_r <= reg_wdata;
        btnp_pkg::REG_SPD0: spd0_r <= reg_wdata;
        btnp_pkg::REG_SPD12: spd12_r <= reg_wdata;
        btnp_pkg::REG_SPD3: spd3_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, registered; unmapped reads as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        btnp_pkg::REG_STATUS: reg_rdata <= status_r;
        btnp_pkg::REG_EN: reg_rdata <= en_r;
        btnp_pkg::REG_INTERRUPT_POLARITY: reg_rdata <= interrupt_polarity_r;
        btnp_pkg::REG_LP_STEP: reg_rdata <= lp_step_r;
        btnp_pkg::REG_NP_STEP: reg_rdata <= np_step_r;
        btnp_pkg::REG_PAUSE_GRP: reg_rdata <= pause_grp_r;
        btnp_pkg::REG_THRESHOLD_HYSTERESIS: reg_rdata <= threshold_hysteresis_r;
        btnp_pkg::REG_TWIST: reg_rdata <= twist_r;
        btnp_pkg::REG_COMDEF: reg_rdata <= comdef_r;
        btnp_pkg::REG_SPD0: reg_rdata <= spd0_r;
        btnp_pkg::REG_SPD12: reg_rdata <= spd12_r;
        btnp_pkg::REG_SPD3: reg_rdata <= spd3_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  sequence s_walk_done;
    state_r == btnp_pkg::BTNP_DONE;
  endsequence

  a_threshold_hysteresis_reset: assert property (@(posedge sys_clk)
    rst |=> threshold_hysteresis_r == btnp_pkg::THRESHOLD_HYSTERESIS_RST)
    else $error("hysteresis reset value wrong");
  a_out_window: assert property (@(posedge sys_clk) disable iff (rst)
    s_walk_done |=>
      out_r == ($past(raw_mode) ? '0 : $past(pressed_nxt)))
    else $error("outputs not updated at window end");
  a_out_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(state_r == btnp_pkg::BTNP_DONE) |-> $stable(out_r))
    else $error("outputs changed mid window");
  a_raw_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (s_walk_done and raw_mode) |=> out_r == '0)
    else $error("outputs used in raw mode");
  a_irq_held: assert property (@(posedge sys_clk) disable iff (rst)
    |pressed_r |=> irq_r)
    else $error("irq dropped while pressed");
  a_irq_pol: assert property (@(posedge sys_clk) disable iff (rst)
    irq_r |=> irq_pin == $past(interrupt_polarity_r[0]))
    else $error("irq polarity wrong");
  a_err_flag: assert property (@(posedge sys_clk) disable iff (rst)
    error_evt |=> status_r[btnp_pkg::ST_ERR] ##1 irq_r)
    else $error("error not recorded");
  a_sticky_out: assert property (@(posedge sys_clk) disable iff (rst)
    status_r[btnp_pkg::ST_OUT] && !reg_rd |=> status_r[btnp_pkg::ST_OUT])
    else $error("output status lost without read");
  a_disabled_off: assert property (@(posedge sys_clk) disable iff (rst)
    s_walk_done ##1 1'b1 |-> (out_r & ~en_r[NCH-1:0]) == '0)
    else $error("disabled channel asserted");
  // a twisted case must not let a fresh press through the walk
  a_twist_block: assert property (@(posedge sys_clk)
    disable iff (rst)
    state_r == btnp_pkg::BTNP_CHAN && twisted && !pressed_r[ch_r[1:0]] |=>
      !pressed_nxt[$past(ch_r[1:0])])
    else $error("press taken while twisted");
endmodule

// ---- tb/btnp_host.sv ----
`timescale 1ns/1ps
// host controller model: register writes, status reads, irq sensing
module btnp_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_pin,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  end
  // address and data flip after use so a stale bus never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // reading status is what clears its sticky bits
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // bounded wait for the irq line to reach its active level
  task automatic wait_irq(input logic act, input int n);
    for (int i = 0; i < n && irq_pin !== act; i++) @(posedge sys_clk);
    #2;
  endtask
endmodule

// ---- tb/button_detect_postproc_bench.sv ----
`timescale 1ns/1ps
// self-checking bench for the button post-processing block
module button_detect_postproc_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic window_done = 1'b0;
  logic [btnp_pkg::NCH*btnp_pkg::DW-1:0] meas = '0;
  logic raw_mode = 1'b0;
  logic error_evt = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [btnp_pkg::NCH-1:0] button_output_pin;
  logic irq_pin;
  logic [7:0] rd_val;
  logic [7:0] v;
  int err_count = 0;
  int checked = 0;
  int seed = 1;
  int threshold_hysteresis = 32;
  int pol = 0;
  int en = 15;
  int grp = 0;
  logic [3:0] pressed = '0;
  logic pm = 1'b1;
  logic cont = 1'b0;
  int npi = 3;
  int lpi = 3;
  int pause = 0;
  int ac = 0;
  int df = 0;
  int tw = 0;
  int spd [4] = '{0, 0, 0, 0};
  int fac [4] = '{1, 4, 8, 16};
  // model baseline per channel, in 1/256 of a count
  int base [4] = '{0, 0, 0, 0};
  logic [7:0] ra [13] = '{8'h18, 8'h11, 8'h0c, 8'h15, 8'h13, 8'h16,
    8'h19, 8'h1a, 8'h25, 8'h28, 8'h2b, 8'h01, 8'h00};
  logic [7:0] rv [13] = '{8'h20, 8'h00, 8'h0f, 8'h03, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  initial forever #25 sys_clk = ~sys_clk;

  btnp_top #(.NCH(btnp_pkg::NCH)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .window_done(window_done), .meas(meas),
    .raw_mode(raw_mode), .error_evt(error_evt),
    .continuous_sampling_select(cont), .power_mode_pin(pm),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .button_output_pin(button_output_pin), .irq_pin(irq_pin));

  btnp_host host_u (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  task automatic fail(input string msg);
    err_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("reg read %h, want %h", got, exp));
  endtask
  task automatic chk_btn(input logic [3:0] exp);
    checked++;
    if (button_output_pin !== exp)
      fail($sformatf("buttons %b, want %b", button_output_pin, exp));
  endtask
  task automatic chk_irq(input logic act);
    logic exp;
    exp = pol[0] ~^ act;
    checked++;
    if (irq_pin !== exp) fail($sformatf("irq %b, want %b", irq_pin, exp));
  endtask
  task automatic print_verdict;
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // measurement values stay off the thresholds by two counts, since the
  // slow baseline may shave one count off the processed value
  function automatic int pick(input int h);
    int x;
    do x = $random(seed) & 255;
    while ((x >= 127 + h && x <= 129 + h) || (x >= 127 - h && x <= 129 - h));
    return x;
  endfunction

  // register write that also keeps the bench's view of the settings
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    case (a)
      8'h0c: en = d;
      8'h11: pol = d;
      8'h13: lpi = d;
      8'h15: npi = d;
      8'h16: begin
        pause = d[3:0];
        grp = d[7:4];
      end
      8'h18: threshold_hysteresis = d;
      8'h19: tw = d;
      8'h1a: begin
        ac = d[3:0];
        df = d[7:4];
      end
      8'h25: spd[0] = d[1:0];
      8'h28: begin
        spd[1] = d[1:0];
        spd[2] = d[5:4];
      end
      8'h2b: spd[3] = d[1:0];
      default: ;
    endcase
  endtask

  // baseline step in 1/256 count; index saturates at 14
  function automatic int bstep(input int c, input bit neg);
    int k;
    int s;
    k = pm ? npi : lpi;
    k = (k & 31) > 14 ? 14 : k & 31;
    if (cont && pm) s = int'(btnp_pkg::FIXED_STEP);
    else if (pm) s = (256 << k) / 72;
    else s = (256 << k) / 9;
    if (neg) s = s * fac[spd[c]];
    return s;
  endfunction

  // one sampling window: reference model then port comparison
  task automatic window(input int m0, input int m1, input int m2,
                        input int m3);
    int m [4];
    int vv [4];
    int s;
    int t;
    bit tw_hit;
    logic [3:0] cand;
    logic [3:0] out;
    m = '{m0, m1, m2, m3};
    tw_hit = 1'b0;
    @(posedge sys_clk);
    #2;
    for (int c = 0; c < 4; c++) meas[16*c +: 16] = m[c][15:0];
    window_done = 1'b1;
    for (int c = 0; c < 4; c++) begin
      vv[c] = m[c] - (base[c] >>> 8);
      // tracking step uses the sign seen before this window's update
      if (!raw_mode && en[c] && !(pause[c] && pressed[c])) begin
        s = bstep(c, vv[c] < 0);
        t = m[c] << 8;
        if (base[c] + s <= t) base[c] += s;
        else if (base[c] > t + s) base[c] -= s;
        else base[c] = t;
      end
      vv[c] = m[c] - (base[c] >>> 8);
    end
    for (int c = 0; c < 4; c++) begin
      if (tw[7] && en[c] && vv[c] < -(tw & 127)) tw_hit = 1'b1;
    end
    for (int c = 0; c < 4; c++) begin
      if (!en[c]) cand[c] = 1'b0;
      else if (pressed[c]) cand[c] = vv[c] > 128 - threshold_hysteresis;
      else cand[c] = vv[c] >= 128 + threshold_hysteresis && !tw_hit;
    end
    out = cand;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (i != j && cand[i] && cand[j]) begin
          if (ac[i] && ac[j] && j < i && vv[i] - vv[j] < threshold_hysteresis &&
              vv[j] - vv[i] < threshold_hysteresis) out[i] = 1'b0;
          if (df[i] && df[j] && vv[j] > vv[i]) out[i] = 1'b0;
          if (grp[i] && grp[j] &&
              (vv[j] > vv[i] || (vv[j] == vv[i] && j < i)))
            out[i] = 1'b0;
        end
      end
    end
    if (raw_mode) out = '0;
    pressed = out;
    repeat (2) @(posedge sys_clk);
    #2;
    window_done = 1'b0;
    repeat (14) @(posedge sys_clk);
    #2;
    chk_btn(out);
    if (!raw_mode) chk_irq(|out);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail("watchdog expired");
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    foreach (ra[i]) begin
      host_u.rd(ra[i], rd_val);
      chk_reg(rd_val, rv[i]);
    end
    for (int a = 0; a < 3; a++) begin
      v = 8'($random(seed));
      host_u.wr(ra[8+a], v);
      host_u.rd(ra[8+a], rd_val);
      chk_reg(rd_val, v);
      host_u.wr(ra[8+a], 8'h00);
    end
    host_u.wr(8'h00, 8'hff);
    host_u.rd(8'h00, rd_val);
    chk_reg(rd_val, 8'h00);
    $display("register test done");
    cfg(8'h15, 8'h00);
    cfg(8'h13, 8'h00);
    cfg(8'h16, 8'h0f);
    window(0, 0, 0, 0);
    window(159, 0, 0, 0);
    window(160, 0, 0, 0);
    host_u.rd(8'h00, rd_val);
    chk_reg(rd_val, 8'h01);
    host_u.rd(8'h00, rd_val);
    chk_reg(rd_val, 8'h00);
    window(97, 170, 0, 0);
    window(96, 170, 0, 0);
    window(0, 96, 0, 0);
    $display("threshold test done");
    cfg(8'h16, 8'h3f);
    window(200, 180, 0, 0);
    window(0, 0, 0, 0);
    cfg(8'h16, 8'h0f);
    cfg(8'h0c, 8'h0e);
    window(200, 0, 0, 0);
    cfg(8'h0c, 8'h0f);
    window(0, 0, 0, 0);
    cfg(8'h11, 8'h01);
    window(0, 0, 200, 0);
    window(0, 0, 0, 0);
    cfg(8'h11, 8'h00);
    cfg(8'h1a, 8'h03);
    window(180, 190, 0, 0);
    window(0, 0, 0, 0);
    cfg(8'h1a, 8'h30);
    window(180, 200, 0, 0);
    window(0, 0, 0, 0);
    cfg(8'h1a, 8'h00);
    $display("group and polarity test done");
    // fast step lifts channel 1's baseline, then its value goes negative
    cfg(8'h15, 8'h0e);
    window(0, 100, 0, 0);
    pm = 1'b0;
    cfg(8'h15, 8'h00);
    cfg(8'h13, 8'h06);
    cfg(8'h19, 8'h8a);
    window(200, 0, 0, 0);
    cfg(8'h28, 8'h03);
    window(200, 0, 0, 0);
    cfg(8'h28, 8'h00);
    cfg(8'h19, 8'h00);
    cfg(8'h13, 8'h00);
    pm = 1'b1;
    window(0, 0, 0, 0);
    $display("baseline and twist test done");
    cont = 1'b1;
    repeat (16) begin
      threshold_hysteresis = 8 + ($random(seed) & 31);
      cfg(8'h18, 8'(threshold_hysteresis));
      window(pick(threshold_hysteresis), pick(threshold_hysteresis), pick(threshold_hysteresis), pick(threshold_hysteresis));
    end
    window(0, 0, 0, 0);
    cont = 1'b0;
    host_u.rd(8'h00, rd_val);
    $display("random threshold test done");
    @(posedge sys_clk);
    #2;
    error_evt = 1'b1;
    @(posedge sys_clk);
    #2;
    error_evt = 1'b0;
    host_u.wait_irq(1'b0, 20);
    chk_irq(1'b1);
    host_u.rd(8'h00, rd_val);
    chk_reg(rd_val, 8'h02);
    raw_mode = 1'b1;
    window(250, 250, 250, 250);
    host_u.wait_irq(1'b0, 20);
    chk_irq(1'b1);
    host_u.rd(8'h00, rd_val);
    chk_reg(rd_val, 8'h04);
    raw_mode = 1'b0;
    $display("error and raw test done");
    print_verdict();
  end
endmodule
